//--- core/sbc_ctrl.sv
// standby controller: standby control register, halt and stop sequencing
// assumes the cpu core reports dedicated writes only after completion
`timescale 1ns/1ps
`include "sbc_consts.svh"

// Summary of operation
// [RULE1] standby control is 8 bits, written only by its dedicated immediate instruction
// [RULE2] dedicated write takes effect only when its two trailing bytes are complements
// [RULE3] non-complement bytes: register unchanged, trap raised, trap address returned
// [RULE4] standby flag cleared only by power-on reset, never by software or pin reset
// [RULE5] standby control register readable at any time
// [RULE6] external reset clears every bit except the standby flag; here the flag bit also reads 0 until the first clock after reset
// [RULE7] halt bit stops cpu clock; peripherals and clock generator keep running
// [RULE8] halt not entered while unmasked request pending or macro service runs
// [RULE9] halt ends on nmi, unmasked maskable or macro service request, any priority
// [RULE10] in a service routine, higher priority request ends halt and is accepted
// [RULE11] equal or lower priority ends halt only; request stays pending; here equal level 3 is accepted when multi_level_select_bit is 0
// [RULE12] after wake nmi vectors; maskable vectors only when enabled and higher
// [RULE13] macro service wake ends halt only if a vectored interrupt follows
// [RULE14] halt bit cleared when the vectored request issues after macro service
// [RULE15] external reset ending halt acts as normal reset, ram kept
// [RULE16] stop bit halts oscillator, all clocks, cpu and peripherals; state kept
// [RULE17] entering stop clears the watchdog counter
// [RULE18] only nmi edge or external reset ends stop; nmi edge restarts oscillator
// [RULE19] counter held clear while nmi active; clocks resume at overflow
// [RULE20] software never sets stop while running from an external clock
// [RULE21] watchdog mode written only by its dedicated write; run bit sticky
// [RULE22] clearing the watchdog through the run bit leaves the prescaler running
// [RULE23] priority flag 1: watchdog beats nmi; 0: nmi beats watchdog
// [RULE24] stop ended by reset restarts oscillator at once; reset vector after
// [RULE25] standby request acts only after the dedicated write completes
module sbc_ctrl #(
    parameter int WD_WIDTH  = `SBC_WD_WIDTH,
    parameter int PRE_WIDTH = `SBC_PRE_WIDTH
) (
    input  wire logic                 clock,          // system clock
    input  wire logic                 rstn,           // external reset, active low
    input  wire logic                 por_n,          // power-on reset, active low
    input  wire sbc_pkg::sbc_dwrite_type standby_control_wr,     // dedicated standby write
    input  wire sbc_pkg::sbc_dwrite_type wdm_wr,      // dedicated watchdog mode write
    input  wire sbc_pkg::sbc_req_type req,            // wake request summary
    input  wire logic                 in_service,     // cpu inside a service routine
    input  wire logic [1:0]           service_pri,    // priority being serviced
    input  wire logic                 multi_level_select_bit, // multi-level select
    input  wire logic                 int_enable,     // cpu interrupts enabled
    input  wire logic                 nmi_pin,        // nmi level, active high
    output logic [7:0]                standby_control_r, // register read data
    output logic [7:0]                watchdog_mode_r,   // watchdog mode read data
    output logic                      cpu_clk_en_r,   // cpu clock enable
    output logic                      osc_en_r,       // oscillator enable
    output logic                      sys_clk_en_r,   // internal clock enable
    output logic                      trap_r,         // op-code trap pulse
    output logic [15:0]               trap_addr_r,    // return address on trap
    output logic                      accept_r,       // wake request accepted pulse
    output logic                      vector_nmi_r,   // nmi vectors first
    output logic                      wd_clear_r      // watchdog clear pulse
);
    sbc_pkg::sbc_state_type state_r;
    sbc_pkg::sbc_state_type state_nxt;
    logic                   sbf_r;
    logic                   nmi_d_r;
    logic [PRE_WIDTH-1:0]   pre_r;
    logic                   wd_ovf;
    logic                   wd_hold;
    logic                   standby_control_ok;
    logic                   wake;
    logic                   higher;
    logic                   nmi_edge;

    assign standby_control_ok  = standby_control_wr.valid && (standby_control_wr.data0 == ~standby_control_wr.data1); // [RULE2] [RULE25]
    assign nmi_edge = nmi_pin && !nmi_d_r;
    // wake regardless of priority
    assign wake     = req.nmi || req.mask_req || req.ms_req;              // [RULE9]
    // lowest level accepts same level only with multi-level select at 0
    assign higher   = !in_service || (req.mask_pri < service_pri) ||
                      ((service_pri == 2'h3) && (req.mask_pri == 2'h3) &&
                       !multi_level_select_bit);                          // [RULE10]

    // standby flag: only power-on reset clears it, pin reset does not
    always_ff @(posedge clock or negedge por_n) begin
        if (!por_n) begin
            sbf_r <= 1'b0;                                                // [RULE4]
        end else if (standby_control_ok && standby_control_wr.data1[`SBC_BIT_SBF]) begin
            sbf_r <= 1'b1;                                                // [RULE4]
        end
    end

    // control bits: all cleared by pin reset, flag position reloaded from sbf_r afterwards
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            standby_control_r <= `SBC_STANDBY_CONTROL_RST;                          // [RULE6]
        end else begin
            standby_control_r[`SBC_BIT_SBF] <= sbf_r;                    // [RULE5]
            if (standby_control_ok) begin
                standby_control_r[`SBC_BIT_HLT] <= standby_control_wr.data1[`SBC_BIT_HLT]; // [RULE1]
                standby_control_r[`SBC_BIT_STP] <= standby_control_wr.data1[`SBC_BIT_STP]; // [RULE1]
                standby_control_r[2]            <= standby_control_wr.data1[2];
                standby_control_r[7:4]          <= standby_control_wr.data1[7:4];
            end else if (state_r == sbc_pkg::SBC_MSVC && !req.ms_busy && req.ms_vect) begin
                standby_control_r[`SBC_BIT_HLT] <= 1'b0;                  // [RULE14]
            end else if ((state_r == sbc_pkg::SBC_HALT && wake && !req.ms_req) ||
                         (state_r == sbc_pkg::SBC_OSCWAIT && wd_ovf)) begin
                standby_control_r[`SBC_BIT_HLT] <= 1'b0;
                standby_control_r[`SBC_BIT_STP] <= 1'b0;
            end
        end
    end

    // trap on a corrupted dedicated standby write
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trap_r      <= 1'b0;
            trap_addr_r <= 16'h0000;
        end else begin
            trap_r <= standby_control_wr.valid && !standby_control_ok;                          // [RULE3]
            if (standby_control_wr.valid && !standby_control_ok) begin
                trap_addr_r <= standby_control_wr.pc;                                // [RULE3]
            end
        end
    end

    // watchdog mode: dedicated write only, fixed bits zero, run bit sticky
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            watchdog_mode_r <= `SBC_WDM_RST;
        end else if (wdm_wr.valid && (wdm_wr.data0 == ~wdm_wr.data1)) begin
            watchdog_mode_r <= (wdm_wr.data1 & `SBC_WDM_FIXMASK) |
                               (watchdog_mode_r & (8'h01 << `SBC_WDM_RUN)); // [RULE21]
        end
    end

    // free prescaler, never cleared by a watchdog clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;                                        // [RULE22]
        end
    end

    // nmi edge detect; pin taken as synchronous
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nmi_d_r <= 1'b0;
        end else begin
            nmi_d_r <= nmi_pin;
        end
    end

    // watchdog cleared on stop entry and held while nmi stays active
    assign wd_hold = (state_r == sbc_pkg::SBC_STOP) ||
                     (state_r == sbc_pkg::SBC_OSCWAIT && nmi_pin);        // [RULE17] [RULE19]

    sbc_wdcnt #(
        .WIDTH(WD_WIDTH)
    ) u_wdcnt (
        .clock     (clock),
        .rstn      (rstn),
        .clear     (wd_hold),
        .tick      (&pre_r),                                              // [RULE22]
        .overflow_r(wd_ovf)
    );

    // standby sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sbc_pkg::SBC_RUN: begin
                // stop entered whenever its bit is set; halt only with no maskable, nmi or busy macro service
                if (standby_control_r[`SBC_BIT_STP]) begin
                    state_nxt = sbc_pkg::SBC_STOP;                        // [RULE16]
                end else if (standby_control_r[`SBC_BIT_HLT] && !req.mask_req &&
                             !req.nmi && !req.ms_busy) begin
                    state_nxt = sbc_pkg::SBC_HALT;                        // [RULE8]
                end
            end
            sbc_pkg::SBC_HALT: begin
                if (req.ms_req) begin
                    state_nxt = sbc_pkg::SBC_MSVC;                        // [RULE13]
                end else if (wake) begin
                    state_nxt = sbc_pkg::SBC_RUN;                         // [RULE9]
                end
            end
            sbc_pkg::SBC_MSVC: begin
                if (!req.ms_busy) begin
                    state_nxt = req.ms_vect ? sbc_pkg::SBC_RUN
                                            : sbc_pkg::SBC_HALT;          // [RULE13]
                end
            end
            sbc_pkg::SBC_STOP: begin
                if (nmi_edge) begin
                    state_nxt = sbc_pkg::SBC_OSCWAIT;                     // [RULE18]
                end
            end
            sbc_pkg::SBC_OSCWAIT: begin
                if (wd_ovf) begin
                    state_nxt = sbc_pkg::SBC_RUN;                         // [RULE19]
                end
            end
            default: state_nxt = sbc_pkg::SBC_RUN;
        endcase
    end

    // reset restarts the oscillator and returns to run with ram untouched
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= sbc_pkg::SBC_RUN;                                  // [RULE15] [RULE24]
        end else begin
            state_r <= state_nxt;
        end
    end

    // clock gating outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cpu_clk_en_r <= 1'b1;
            osc_en_r     <= 1'b1;                                         // [RULE24]
            sys_clk_en_r <= 1'b1;
        end else begin
            cpu_clk_en_r <= (state_nxt == sbc_pkg::SBC_RUN);              // [RULE7]
            osc_en_r     <= (state_nxt != sbc_pkg::SBC_STOP);             // [RULE16] [RULE18]
            sys_clk_en_r <= (state_nxt != sbc_pkg::SBC_STOP) &&
                            (state_nxt != sbc_pkg::SBC_OSCWAIT);          // [RULE16] [RULE19]
        end
    end

    // wake outcome and watchdog clear pulse
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            accept_r     <= 1'b0;
            vector_nmi_r <= 1'b0;
            wd_clear_r   <= 1'b0;
        end else begin
            wd_clear_r <= (state_r == sbc_pkg::SBC_RUN) &&
                          (state_nxt == sbc_pkg::SBC_STOP);               // [RULE17]
            if (state_r == sbc_pkg::SBC_HALT && wake && !req.ms_req) begin
                // nmi always accepted; maskable only if enabled and higher
                accept_r     <= req.nmi || (int_enable && higher);        // [RULE11] [RULE12]
                vector_nmi_r <= req.nmi &&
                                !(req.wdt && watchdog_mode_r[`SBC_WDM_PRC]); // [RULE23]
            end else if (state_r == sbc_pkg::SBC_MSVC && !req.ms_busy && req.ms_vect) begin
                accept_r     <= int_enable && higher;                     // [RULE12]
                vector_nmi_r <= 1'b0;
            end else begin
                accept_r     <= 1'b0;
                vector_nmi_r <= 1'b0;
            end
        end
    end
endmodule

//--- core/sbc_consts.svh
// constants for the standby halt/stop controller
// assumes a cpu core that decodes the dedicated immediate writes
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
`define SBC_STANDBY_CONTROL_RST    8'h00
`define SBC_BIT_HLT     0
`define SBC_BIT_STP     1
`define SBC_BIT_SBF     3
`define SBC_WDM_RST     8'h00
`define SBC_WDM_RUN     7
`define SBC_WDM_PRC     4
`define SBC_WDM_FIXMASK 8'h9e
`define SBC_WD_WIDTH    16
`define SBC_PRE_WIDTH   4
`endif

//--- core/sbc_pkg.sv
// types for the standby halt/stop controller
// used by the controller, its checker and the testbench
package sbc_pkg;
    typedef enum logic [4:0] {
        SBC_RUN     = 5'h01,
        SBC_HALT    = 5'h02,
        SBC_MSVC    = 5'h04,
        SBC_STOP    = 5'h08,
        SBC_OSCWAIT = 5'h10
    } sbc_state_type;

    // dedicated immediate write from the cpu decoder
    typedef struct packed {
        logic       valid;   // instruction completed this cycle
        logic [7:0] data0;   // first immediate byte
        logic [7:0] data1;   // second immediate byte
        logic [15:0] pc;     // address of the instruction
    } sbc_dwrite_type;

    // wake-up request summary from the interrupt controller
    typedef struct packed {
        logic       nmi;       // non-maskable request pending
        logic       wdt;       // watchdog interrupt pending
        logic       mask_req;  // unmasked maskable request
        logic [1:0] mask_pri;  // its priority level 0..3
        logic       ms_req;    // unmasked macro service request
        logic       ms_busy;   // macro service running
        logic       ms_vect;   // vectored interrupt at end of service
    } sbc_req_type;
endpackage

//--- core/sbc_wdcnt.sv
// watchdog counter used to time oscillator stabilisation
// assumes a free prescaler tick; clear does not touch the prescaler
`timescale 1ns/1ps
`include "sbc_consts.svh"
module sbc_wdcnt #(
    parameter int WIDTH = `SBC_WD_WIDTH
) (
    input  wire logic clock,     // system clock
    input  wire logic rstn,      // async reset, active low
    input  wire logic clear,     // hold counter at zero
    input  wire logic tick,      // prescaled count clock
    output logic      overflow_r // one-cycle overflow pulse
);
    logic [WIDTH-1:0] cnt_r;

    // counter and overflow pulse
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_r      <= '0;
            overflow_r <= 1'b0;
        end else if (clear) begin
            cnt_r      <= '0;
            overflow_r <= 1'b0;
        end else begin
            overflow_r <= tick && (&cnt_r);
            if (tick) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule

//--- testbench/sbc_ctrl_asserts.sv
// checker on the ports of the standby controller
// assumes one clock; pin reset disables every property
`timescale 1ns/1ps
module sbc_ctrl_asserts #(
    parameter int WD_WIDTH  = 16,
    parameter int PRE_WIDTH = 4
) (
    input wire logic                    clock,             // system clock
    input wire logic                    rstn,              // pin reset
    input wire logic                    por_n,             // power-on reset
    input wire sbc_pkg::sbc_dwrite_type standby_control_wr,           // standby write
    input wire sbc_pkg::sbc_req_type    req,               // wake requests
    input wire logic                    nmi_pin,           // nmi level
    input wire logic [7:0]              standby_control_r, // standby register
    input wire logic [7:0]              watchdog_mode_r,   // watchdog mode
    input wire logic                    cpu_clk_en_r,      // cpu clock enable
    input wire logic                    osc_en_r,          // oscillator enable
    input wire logic                    sys_clk_en_r,      // internal clock enable
    input wire logic                    trap_r,            // trap pulse
    input wire logic                    wd_clear_r         // watchdog clear
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // write checks, halt entry and refusal, stop sequencing
    bad_trap_a: assert property (standby_control_wr.valid && standby_control_wr.data0 != ~standby_control_wr.data1
        |-> ##[1:2] trap_r) else $error("no trap after bad write");
    bad_keep_a: assert property (standby_control_wr.valid && standby_control_wr.data0 != ~standby_control_wr.data1
        && standby_control_r[1:0] == 2'b00 |=> standby_control_r[1:0] == 2'b00)
        else $error("bad write changed register");
    halt_enter_a: assert property (standby_control_wr.valid && standby_control_wr.data0 == ~standby_control_wr.data1
        && standby_control_wr.data1 == 8'h01 && !(req.mask_req || req.nmi || req.ms_req || req.ms_busy)
        |=> standby_control_r[0] ##[1:2] (!cpu_clk_en_r && sys_clk_en_r))
        else $error("halt not entered");
    halt_refuse_a: assert property ((req.mask_req && cpu_clk_en_r
        && !standby_control_r[1])[*3] |=> cpu_clk_en_r) else $error("halt with request");
    halt_wake_a: assert property (!cpu_clk_en_r && sys_clk_en_r && req.mask_req
        |-> ##[1:2] cpu_clk_en_r) else $error("halt not released");
    stop_clear_a: assert property ($rose(standby_control_r[1])
        |-> ##[0:3] wd_clear_r) else $error("no watchdog clear on stop");
    stop_hold_a: assert property (!osc_en_r && !nmi_pin |=> !osc_en_r)
        else $error("stop left without nmi");
    osc_restart_a: assert property (!osc_en_r && $rose(nmi_pin)
        |-> ##[1:3] osc_en_r) else $error("oscillator not restarted");
    nmi_hold_a: assert property (!sys_clk_en_r && nmi_pin && $past(nmi_pin)
        |=> !sys_clk_en_r) else $error("clock resumed with nmi active");
    run_sticky_a: assert property (watchdog_mode_r[7] |=> watchdog_mode_r[7])
        else $error("watchdog run bit cleared");
    flag_keep_a: assert property (por_n && $past(por_n) && $past(por_n, 2)
        |-> !$fell(standby_control_r[3])) else $error("standby flag cleared");
endmodule

bind sbc_ctrl sbc_ctrl_asserts #(.WD_WIDTH(WD_WIDTH), .PRE_WIDTH(PRE_WIDTH)) u_chk (
    .clock, .rstn, .por_n, .standby_control_wr, .req, .nmi_pin, .standby_control_r,
    .watchdog_mode_r, .cpu_clk_en_r, .osc_en_r, .sys_clk_en_r, .trap_r, .wd_clear_r);

//--- testbench/sbc_cpu_model.sv
// cpu side model: issues the dedicated immediate writes
// assumes callers enter issue at a falling edge or later
`timescale 1ns/1ps
module sbc_cpu_model #(
    parameter bit EXT_CLOCK = 1'b0
) (
    input  wire logic               clock,   // system clock
    output sbc_pkg::sbc_dwrite_type standby_control_wr, // standby write
    output sbc_pkg::sbc_dwrite_type wdm_wr   // watchdog mode write
);
    initial standby_control_wr = '0;
    initial wdm_wr = '0;
    // one-cycle completed write; flip corrupts the check byte on command
    task automatic issue(input bit to_wdm, input logic [7:0] value,
                         input logic [7:0] flip, input logic [15:0] pc);
        sbc_pkg::sbc_dwrite_type w;
        @(negedge clock);
        w.valid = 1'b1;
        w.data1 = value;
        if (EXT_CLOCK && !to_wdm) w.data1[1] = 1'b0; // no stop on external clock
        w.data0 = ~w.data1 ^ flip; // complement byte
        w.pc = pc;
        if (to_wdm) wdm_wr = w;
        else standby_control_wr = w;
        @(negedge clock);
        standby_control_wr = '0;
        wdm_wr = '0;
    endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the standby controller
// assumes shortened watchdog counts; inputs change at falling edges
`timescale 1ns/1ps
module testbench;
    logic                    clock = 1'b0;      // system clock
    logic                    rstn = 1'b0;       // pin reset
    logic                    por_n = 1'b0;      // power-on reset
    sbc_pkg::sbc_req_type    req = '0;          // wake requests
    logic                    in_svc = 1'b0;     // in service routine
    logic [1:0]              svc_pri = 2'h0;    // serviced priority
    logic                    msel = 1'b0;       // multi-level select
    logic                    ie = 1'b0;         // interrupts enabled
    logic                    nmi_pin = 1'b0;    // nmi level
    sbc_pkg::sbc_dwrite_type standby_control_wr, wdm_wr;   // dedicated writes
    logic [7:0]              standby_control, watchdog_mode;         // register reads
    logic [15:0]             trap_addr;         // trap address
    logic                    cpu_en, osc_en, sys_en, trap, acc, wdc, vec;
    logic                    acc_seen, trap_seen, wdc_seen, vec_seen; // pulse catchers
    int                      err_total = 0;
    int                      n_compared = 0;

    always #5 clock = ~clock;
    sbc_cpu_model cpu (.clock(clock), .standby_control_wr(standby_control_wr), .wdm_wr(wdm_wr));
    sbc_ctrl #(.WD_WIDTH(4), .PRE_WIDTH(1)) DUT (.clock(clock), .rstn(rstn), .por_n(por_n),
        .standby_control_wr(standby_control_wr), .wdm_wr(wdm_wr), .req(req), .in_service(in_svc),
        .service_pri(svc_pri), .multi_level_select_bit(msel), .int_enable(ie),
        .nmi_pin(nmi_pin), .standby_control_r(standby_control), .watchdog_mode_r(watchdog_mode),
        .cpu_clk_en_r(cpu_en), .osc_en_r(osc_en), .sys_clk_en_r(sys_en), .trap_r(trap),
        .trap_addr_r(trap_addr), .accept_r(acc), .vector_nmi_r(vec), .wd_clear_r(wdc));

    // pulses last one cycle, so latch them for later comparison
    always @(posedge clock) begin
        if (acc === 1'b1) acc_seen <= 1'b1;
        if (trap === 1'b1) trap_seen <= 1'b1;
        if (wdc === 1'b1) wdc_seen <= 1'b1;
        if (vec === 1'b1) vec_seen <= 1'b1;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // accepted only when enabled and outranking the routine being served, or both at level 3 with select 0
    function automatic logic exp_accept(input logic [1:0] p, input logic [1:0] sp,
                                        input logic ins, input logic ms, input logic en);
        return en && (!ins || p < sp || (sp == 2'd3 && p == 2'd3 && !ms));
    endfunction

    // hang guard, far beyond the expected run length
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        report_and_stop();
    end

    initial begin
        int i, n;
        logic [15:0] pc_v;
        logic exp_a;
        n = $urandom(32'h56ac);
        cyc(6);
        rstn = 1'b1;
        por_n = 1'b1;
        cyc(2);
        check("reset", {standby_control, cpu_en, osc_en, sys_en}, 11'h007);
        cpu.issue(0, 8'h08, 8'h00, 16'h0);
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(2);
        check("flag", standby_control, 8'h08);
        por_n = 1'b0;
        cyc(2);
        por_n = 1'b1;
        cyc(2);
        check("por", standby_control[3], 1'b0);
        // corrupted check bytes at random
        for (i = 0; i < 4; i++) begin
            pc_v = $urandom;
            trap_seen = 1'b0;
            cpu.issue(0, $urandom, $urandom_range(255, 1), pc_v);
            cyc(2);
            check("trap", {trap_seen, standby_control}, 9'h100);
            check("taddr", trap_addr, pc_v);
        end
        // halt, then wake with random priority and service state
        for (i = 0; i < 8; i++) begin
            cpu.issue(0, 8'h01, 8'h00, 16'h0);
            cyc(3);
            check("halt", {cpu_en, sys_en, standby_control[0]}, 3'b011);
            {in_svc, svc_pri, msel, ie, req.mask_pri} = $urandom;
            acc_seen = 1'b0;
            req.mask_req = 1'b1;
            cyc(3);
            check("wake", {cpu_en, standby_control[0]}, 2'b10);
            exp_a = exp_accept(req.mask_pri, svc_pri, in_svc, msel, ie);
            check("accept", acc_seen, exp_a);
            req.mask_req = 1'b0;
            cyc(2);
        end
        in_svc = 1'b0;
        req.mask_req = 1'b1;
        cpu.issue(0, 8'h01, 8'h00, 16'h0);
        cyc(4);
        check("refuse", cpu_en, 1'b1);
        cpu.issue(0, 8'h00, 8'h00, 16'h0);
        req.mask_req = 1'b0;
        cpu.issue(0, 8'h01, 8'h00, 16'h0);
        cyc(3);
        // macro service without, then with, a vectored request at its end
        for (i = 0; i < 2; i++) begin
            req.ms_vect = i[0];
            req.ms_req = 1'b1;
            req.ms_busy = 1'b1;
            cyc(3);
            req.ms_req = 1'b0;
            req.ms_busy = 1'b0;
            cyc(3);
            check("msvc", {cpu_en, standby_control[0]}, i ? 2'b10 : 2'b01);
        end
        req.ms_vect = 1'b0;
        wdc_seen = 1'b0;
        cpu.issue(0, 8'h02, 8'h00, 16'h0);
        cyc(3);
        check("stop", {osc_en, sys_en, cpu_en, wdc_seen}, 4'b0001);
        req.mask_req = 1'b1;
        cyc(4);
        check("stophold", osc_en, 1'b0);
        req.mask_req = 1'b0;
        nmi_pin = 1'b1;
        cyc(30);
        check("nmiheld", {osc_en, sys_en}, 2'b10);
        nmi_pin = 1'b0;
        n = 0;
        while (sys_en !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        // 16 counter ticks, one every second clock, plus the overflow pulse edge
        check("ovf", n >= 32 && n <= 33, 1'b1);
        cpu.issue(0, 8'h00, 8'h00, 16'h0);
        cpu.issue(1, 8'hff, 8'h00, 16'h0);
        cyc(2);
        check("wdm", watchdog_mode, 8'h9e);
        cpu.issue(1, 8'h00, 8'h00, 16'h0);
        cyc(2);
        check("run", watchdog_mode[7], 1'b1);
        // nmi wakes halt with a watchdog request beside it, priority flag 0 then 1
        for (i = 0; i < 2; i++) begin
            cpu.issue(1, {3'h0, i[0], 4'h0}, 8'h00, 16'h0);
            cpu.issue(0, 8'h01, 8'h00, 16'h0);
            cyc(3);
            acc_seen = 1'b0;
            vec_seen = 1'b0;
            req.wdt = 1'b1;
            req.nmi = 1'b1;
            cyc(3);
            check("nmiwake", {cpu_en, acc_seen, vec_seen}, {2'b11, !i[0]});
            req.nmi = 1'b0;
            req.wdt = 1'b0;
            cyc(2);
        end
        // pin reset ends halt, then stop; oscillator back at once
        for (i = 1; i < 3; i++) begin
            cpu.issue(0, i[7:0], 8'h00, 16'h0);
            cyc(3);
            rstn = 1'b0;
            cyc(1);
            check("rstwake", {osc_en, cpu_en}, 2'b11);
            rstn = 1'b1;
            cyc(2);
            check("rstrun", {standby_control[1:0], sys_en}, 3'b001);
        end
        report_and_stop();
    end
endmodule
